/* File: logic/csr_link_if.sv */
// CSR bus between the system CPU side and the register bank
`timescale 1ns/10ps
interface csr_link_if;
  logic [13:0] csr_a;
  logic        csr_we;
  logic        csr_re;
  logic [31:0] csr_di;
  logic [31:0] csr_do;

  modport bank (
    input  csr_a,
    input  csr_we,
    input  csr_re,
    input  csr_di,
    output csr_do
  );

  modport master (
    output csr_a,
    output csr_we,
    output csr_re,
    output csr_di,
    input  csr_do
  );
endinterface

/* File: logic/sdram_ctrl_csr_master.sv */
// CPU-side CSR master that forwards software requests and guards misuse
`timescale 1ns/10ps
module sdram_ctrl_csr_master (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Software port
  input  wire logic [13:0] sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_write,
  input  wire logic        sw_read,
  output logic      [31:0] sw_rdata,
  output logic             sw_refused,
  // CSR bus
  csr_link_if.master       csr
);
  logic        shadow_reset;
  logic        shadow_cke;
  logic        ready_seen;
  logic        read_delay;
  logic [13:0] a_q;
  logic        we_q;
  logic        re_q;
  logic [31:0] di_q;

  wire to_system = sw_addr == sdram_ctrl_pkg::OFS_SYSTEM;
  wire to_timing = sw_addr == sdram_ctrl_pkg::OFS_TIMING;
  wire to_delay  = sw_addr == sdram_ctrl_pkg::OFS_DELAY;
  // Timing changes only under controller reset
  wire bad_timing = to_timing & ~shadow_reset;
  // Once set, CKE may only drop with reset held
  wire bad_cke = to_system & shadow_cke & ~sw_wdata[sdram_ctrl_pkg::SYS_CKE] &
                 ~sw_wdata[sdram_ctrl_pkg::SYS_RESET];
  // Phase step only after a ready readback
  wire bad_phase = to_delay & sw_wdata[sdram_ctrl_pkg::DLY_PSEN] & ~ready_seen;
  wire refuse    = sw_write & (bad_timing | bad_cke | bad_phase);
  wire pass_wr   = sw_write & ~refuse;
  wire sys_wr    = pass_wr & to_system;

  assign csr.csr_a  = a_q;
  assign csr.csr_we = we_q;
  assign csr.csr_re = re_q;
  assign csr.csr_di = di_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q        <= '0;
      we_q       <= 1'h0;
      re_q       <= 1'h0;
      di_q       <= sdram_ctrl_pkg::ZERO_WORD;
      sw_refused <= 1'h0;
    end else begin
      a_q        <= sw_addr;
      we_q       <= pass_wr;
      re_q       <= sw_read;
      di_q       <= sw_wdata;
      sw_refused <= refuse;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow_reset <= sdram_ctrl_pkg::SYS_RESET_RST;
      shadow_cke   <= sdram_ctrl_pkg::SYS_CKE_RST;
      ready_seen   <= 1'h0;
      read_delay   <= 1'h0;
      sw_rdata     <= sdram_ctrl_pkg::ZERO_WORD;
    end else begin
      if (sys_wr) begin
        shadow_reset <= sw_wdata[sdram_ctrl_pkg::SYS_RESET];
        shadow_cke   <= sw_wdata[sdram_ctrl_pkg::SYS_CKE];
      end
      read_delay <= re_q & (a_q == sdram_ctrl_pkg::OFS_DELAY);
      if (read_delay) begin
        ready_seen <= csr.csr_do[sdram_ctrl_pkg::DLY_READY];
      end else if (pass_wr & to_delay & sw_wdata[sdram_ctrl_pkg::DLY_PSEN]) begin
        ready_seen <= 1'h0;
      end
      sw_rdata <= csr.csr_do;
    end
  end
endmodule

/* File: logic/sdram_ctrl_pkg.sv */
// Shared constants for the SDRAM controller register bank and its CSR master
package sdram_ctrl_pkg;
  // Bus geometry
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 32;
  // Register byte offsets
  localparam logic [13:0] OFS_SYSTEM  = 14'h0000;
  localparam logic [13:0] OFS_DIRECT  = 14'h0004;
  localparam logic [13:0] OFS_TIMING  = 14'h0008;
  localparam logic [13:0] OFS_DELAY   = 14'h000C;
  // System control fields
  localparam int unsigned SYS_BYPASS  = 0;
  localparam int unsigned SYS_RESET   = 1;
  localparam int unsigned SYS_CKE     = 2;
  localparam logic        SYS_BYPASS_RST = 1'h1;
  localparam logic        SYS_RESET_RST  = 1'h1;
  localparam logic        SYS_CKE_RST    = 1'h0;
  // Direct command fields
  localparam int unsigned CMD_CS      = 0;
  localparam int unsigned CMD_WE      = 1;
  localparam int unsigned CMD_CAS     = 2;
  localparam int unsigned CMD_RAS     = 3;
  localparam int unsigned CMD_A_LO    = 4;
  localparam int unsigned CMD_A_HI    = 16;
  localparam int unsigned CMD_BA_LO   = 17;
  localparam int unsigned CMD_BA_HI   = 18;
  localparam int unsigned A_W         = 13;
  localparam int unsigned BA_W        = 2;
  // Memory timing fields
  localparam int unsigned TIM_RP_LO   = 0;
  localparam int unsigned TIM_RP_HI   = 2;
  localparam int unsigned TIM_RCD_LO  = 3;
  localparam int unsigned TIM_RCD_HI  = 5;
  localparam int unsigned TIM_CL      = 6;
  localparam int unsigned TIM_REFI_LO = 7;
  localparam int unsigned TIM_REFI_HI = 17;
  localparam int unsigned TIM_RFC_LO  = 18;
  localparam int unsigned TIM_RFC_HI  = 21;
  localparam int unsigned TIM_WR_LO   = 22;
  localparam int unsigned TIM_WR_HI   = 23;
  localparam logic [2:0]  TIM_RP_RST   = 3'h2;
  localparam logic [2:0]  TIM_RCD_RST  = 3'h2;
  localparam logic        TIM_CL_RST   = 1'h0;
  localparam logic [10:0] TIM_REFI_RST = 11'h2E4;
  localparam logic [3:0]  TIM_RFC_RST  = 4'h8;
  localparam logic [1:0]  TIM_WR_RST   = 2'h1;
  // Capture delay and phase fields
  localparam int unsigned DLY_RST     = 0;
  localparam int unsigned DLY_CE      = 1;
  localparam int unsigned DLY_INC     = 2;
  localparam int unsigned DLY_PSEN    = 3;
  localparam int unsigned DLY_PSINC   = 4;
  localparam int unsigned DLY_READY   = 5;
  localparam int unsigned DLY_LOCK_LO = 6;
  localparam int unsigned DLY_LOCK_HI = 7;
  localparam int unsigned LOCK_W      = 2;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;
endpackage

/* File: logic/sdram_ctrl_register_bank.sv */
// Control register bank of the DDR SDRAM controller, CSR bus slave end
// How it works
// - Bypass bit hands pins to CPU path
// - Reset bit holds controller reset, default one
// - CKE bit drives clock-enable pin always
// - Software keeps CKE set after early init; master lets it drop with reset bit set
// - Direct command pulses command lines one cycle
// - Direct command bits ignored unless bypass enabled; address and bank fields always stored
// - Bits 0-3 drive CS WE CAS RAS low
// - Address and bank fields hold pin levels
// - Address updates with the command pulse
// - Software holds reset while changing timing
// - Precharge wait field, default two
// - Activate wait field, default two
// - CAS latency bit: two or three
// - Refresh interval field, default 740
// - Refresh recovery field, default eight
// - Write recovery field, default one
// - Delay writes pulse controls one cycle
// - Delay reset bit overrides other bits
// - Tap step, direction from bit two
// - Phase step pulse, direction from bit four
// - Ready bit mirrors clock manager ready
// - Lock inputs pass two-flop synchroniser
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
module sdram_ctrl_register_bank (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_n,
  // CSR bus
  csr_link_if.bank           csr,
  // Scheduler command path
  input  wire logic          sched_cs_n,
  input  wire logic          sched_we_n,
  input  wire logic          sched_cas_n,
  input  wire logic          sched_ras_n,
  input  wire logic [12:0]   sched_a,
  input  wire logic [1:0]    sched_ba,
  // SDRAM command pins
  output logic               sdram_cke,
  output logic               sdram_cs_n,
  output logic               sdram_we_n,
  output logic               sdram_cas_n,
  output logic               sdram_ras_n,
  output logic [12:0]        sdram_a,
  output logic [1:0]         sdram_ba,
  // Controller mode
  output logic               bypass,
  output logic               ctrl_reset,
  // Timing settings
  output logic [2:0]         t_precharge,
  output logic [2:0]         t_activate,
  output logic               cas_latency3,
  output logic [10:0]        t_refresh_interval,
  output logic [3:0]         t_refresh_recovery,
  output logic [1:0]         t_write_recovery,
  // Capture delay and strobe phase
  output logic               tap_reset,
  output logic               tap_step,
  output logic               tap_increment,
  output logic               phase_step,
  output logic               phase_increment,
  input  wire logic          phase_ready,
  input  wire logic [1:0]    clock_lock
);
  logic [12:0] cmd_a;
  logic [1:0]  cmd_ba;
  logic [1:0]  lock_meta;
  logic [1:0]  lock_sync;
  logic [31:0] read_word;

  wire hit_system = csr.csr_a == sdram_ctrl_pkg::OFS_SYSTEM;
  wire hit_direct = csr.csr_a == sdram_ctrl_pkg::OFS_DIRECT;
  wire hit_timing = csr.csr_a == sdram_ctrl_pkg::OFS_TIMING;
  wire hit_delay  = csr.csr_a == sdram_ctrl_pkg::OFS_DELAY;
  wire wr_system  = csr.csr_we & hit_system;
  wire wr_direct  = csr.csr_we & hit_direct;
  wire wr_timing  = csr.csr_we & hit_timing;
  wire wr_delay   = csr.csr_we & hit_delay;
  wire [31:0] di  = csr.csr_di;

  // Command issued only with bypass on
  wire issue = wr_direct & bypass;
  wire [12:0] next_cmd_a  = wr_direct ? di[sdram_ctrl_pkg::CMD_A_HI:sdram_ctrl_pkg::CMD_A_LO] : cmd_a;
  wire [1:0]  next_cmd_ba = wr_direct ? di[sdram_ctrl_pkg::CMD_BA_HI:sdram_ctrl_pkg::CMD_BA_LO] : cmd_ba;
  // Pin selection: scheduler or CPU path
  wire next_cs_n  = bypass ? ~(issue & di[sdram_ctrl_pkg::CMD_CS])  : sched_cs_n;
  wire next_we_n  = bypass ? ~(issue & di[sdram_ctrl_pkg::CMD_WE])  : sched_we_n;
  wire next_cas_n = bypass ? ~(issue & di[sdram_ctrl_pkg::CMD_CAS]) : sched_cas_n;
  wire next_ras_n = bypass ? ~(issue & di[sdram_ctrl_pkg::CMD_RAS]) : sched_ras_n;
  wire [12:0] next_pin_a  = bypass ? next_cmd_a  : sched_a;
  wire [1:0]  next_pin_ba = bypass ? next_cmd_ba : sched_ba;

  // Delay write decode, reset bit masks the rest
  wire dly_rst = wr_delay & di[sdram_ctrl_pkg::DLY_RST];
  wire dly_any = wr_delay & ~di[sdram_ctrl_pkg::DLY_RST];
  wire next_tap_step  = dly_any & di[sdram_ctrl_pkg::DLY_CE];
  wire next_tap_inc   = dly_any & di[sdram_ctrl_pkg::DLY_INC];
  wire next_ps_step   = dly_any & di[sdram_ctrl_pkg::DLY_PSEN];
  wire next_ps_inc    = dly_any & di[sdram_ctrl_pkg::DLY_PSINC];

  // Read mux, unread bits zero
  wire [31:0] rd_system = {29'h0, sdram_cke, ctrl_reset, bypass};
  wire [31:0] rd_direct = {13'h0, cmd_ba, cmd_a, 4'h0};
  wire [31:0] rd_timing = {8'h00, t_write_recovery, t_refresh_recovery, t_refresh_interval,
                           cas_latency3, t_activate, t_precharge};
  wire [31:0] rd_delay  = {24'h0, lock_sync, phase_ready, 5'h0};
  wire [31:0] next_read = ~csr.csr_re ? sdram_ctrl_pkg::ZERO_WORD :
                          hit_system  ? rd_system :
                          hit_direct  ? rd_direct :
                          hit_timing  ? rd_timing :
                          hit_delay   ? rd_delay  : sdram_ctrl_pkg::ZERO_WORD;
  assign csr.csr_do = read_word;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bypass     <= sdram_ctrl_pkg::SYS_BYPASS_RST;
      ctrl_reset <= sdram_ctrl_pkg::SYS_RESET_RST;
      sdram_cke  <= sdram_ctrl_pkg::SYS_CKE_RST;
    end else if (wr_system) begin
      bypass     <= di[sdram_ctrl_pkg::SYS_BYPASS];
      ctrl_reset <= di[sdram_ctrl_pkg::SYS_RESET];
      sdram_cke  <= di[sdram_ctrl_pkg::SYS_CKE];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      t_precharge        <= sdram_ctrl_pkg::TIM_RP_RST;
      t_activate         <= sdram_ctrl_pkg::TIM_RCD_RST;
      cas_latency3       <= sdram_ctrl_pkg::TIM_CL_RST;
      t_refresh_interval <= sdram_ctrl_pkg::TIM_REFI_RST;
      t_refresh_recovery <= sdram_ctrl_pkg::TIM_RFC_RST;
      t_write_recovery   <= sdram_ctrl_pkg::TIM_WR_RST;
    end else if (wr_timing) begin
      t_precharge        <= di[sdram_ctrl_pkg::TIM_RP_HI:sdram_ctrl_pkg::TIM_RP_LO];
      t_activate         <= di[sdram_ctrl_pkg::TIM_RCD_HI:sdram_ctrl_pkg::TIM_RCD_LO];
      cas_latency3       <= di[sdram_ctrl_pkg::TIM_CL];
      t_refresh_interval <= di[sdram_ctrl_pkg::TIM_REFI_HI:sdram_ctrl_pkg::TIM_REFI_LO];
      t_refresh_recovery <= di[sdram_ctrl_pkg::TIM_RFC_HI:sdram_ctrl_pkg::TIM_RFC_LO];
      t_write_recovery   <= di[sdram_ctrl_pkg::TIM_WR_HI:sdram_ctrl_pkg::TIM_WR_LO];
    end
  end

  // Stored direct fields, kept even with bypass off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_a  <= '0;
      cmd_ba <= '0;
    end else begin
      cmd_a  <= next_cmd_a;
      cmd_ba <= next_cmd_ba;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdram_cs_n  <= 1'h1;
      sdram_we_n  <= 1'h1;
      sdram_cas_n <= 1'h1;
      sdram_ras_n <= 1'h1;
      sdram_a     <= '0;
      sdram_ba    <= '0;
    end else begin
      sdram_cs_n  <= next_cs_n;
      sdram_we_n  <= next_we_n;
      sdram_cas_n <= next_cas_n;
      sdram_ras_n <= next_ras_n;
      sdram_a     <= next_pin_a;
      sdram_ba    <= next_pin_ba;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tap_reset       <= 1'h0;
      tap_step        <= 1'h0;
      tap_increment   <= 1'h0;
      phase_step      <= 1'h0;
      phase_increment <= 1'h0;
    end else begin
      tap_reset       <= dly_rst;
      tap_step        <= next_tap_step;
      tap_increment   <= next_tap_inc;
      phase_step      <= next_ps_step;
      phase_increment <= next_ps_inc;
    end
  end

  // Lock inputs may be asynchronous: only the second stage is read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_meta <= '0;
      lock_sync <= '0;
    end else begin
      lock_meta <= clock_lock;
      lock_sync <= lock_meta;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_word <= sdram_ctrl_pkg::ZERO_WORD;
    end else begin
      read_word <= next_read;
    end
  end
endmodule

/* File: testbench/sdram_ctrl_register_bank_sva.sv */
// Concurrent checks on the CSR link and the register bank pins
`timescale 1ns/10ps
module sdram_ctrl_register_bank_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // CSR link
  input wire logic [13:0] csr_a,
  input wire logic        csr_we,
  input wire logic        csr_re,
  input wire logic [31:0] csr_di,
  input wire logic [31:0] csr_do,
  // Bank pins
  input wire logic        sched_cs_n,
  input wire logic [12:0] sched_a,
  input wire logic        sdram_cke,
  input wire logic        sdram_cs_n,
  input wire logic        sdram_we_n,
  input wire logic        sdram_cas_n,
  input wire logic        sdram_ras_n,
  input wire logic [12:0] sdram_a,
  input wire logic [1:0]  sdram_ba,
  input wire logic        bypass,
  input wire logic        ctrl_reset,
  input wire logic        tap_reset,
  input wire logic        tap_step,
  input wire logic        phase_step,
  input wire logic        phase_ready,
  input wire logic [1:0]  clock_lock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire       wr_sys = csr_we && csr_a == sdram_ctrl_pkg::OFS_SYSTEM;
  wire       wr_cmd = csr_we && csr_a == sdram_ctrl_pkg::OFS_DIRECT;
  wire       wr_dly = csr_we && csr_a == sdram_ctrl_pkg::OFS_DELAY;
  wire [3:0] cmd_n  = {sdram_ras_n, sdram_cas_n, sdram_we_n, sdram_cs_n};
  AST_SYS_WRITE: assert property (wr_sys |=> {sdram_cke, ctrl_reset, bypass} == $past(csr_di[2:0]))
    else $error("system bits not applied");
  AST_CKE_HOLD: assert property (!wr_sys |=> $stable(sdram_cke))
    else $error("clock enable moved");
  AST_CMD_PULSE: assert property (wr_cmd && bypass |=>
    cmd_n == ~$past(csr_di[3:0]) && {sdram_ba, sdram_a} == $past(csr_di[18:4]))
    else $error("direct command wrong");
  AST_CMD_IDLE: assert property (bypass && !csr_we |=> cmd_n == 4'hF)
    else $error("command lines not idle");
  AST_SCHED_PATH: assert property (!bypass && !wr_sys |=>
    sdram_cs_n == $past(sched_cs_n) && sdram_a == $past(sched_a))
    else $error("scheduler path not followed");
  AST_DO_IDLE: assert property (!csr_re |=> csr_do == sdram_ctrl_pkg::ZERO_WORD)
    else $error("read data outside slot");
  AST_READ_SYS: assert property (csr_re && csr_a == sdram_ctrl_pkg::OFS_SYSTEM |=>
    csr_do == {29'h0, $past(sdram_cke), $past(ctrl_reset), $past(bypass)})
    else $error("system readback wrong");
  AST_READ_DLY: assert property (csr_re && csr_a == sdram_ctrl_pkg::OFS_DELAY |=>
    csr_do == {24'h0, $past(clock_lock, 3), $past(phase_ready), 5'h0})
    else $error("delay status wrong");
  AST_DLY_PULSE: assert property (wr_dly |=> {tap_reset, tap_step, phase_step} ==
    ($past(csr_di[0]) ? 3'h4 : {1'h0, $past(csr_di[1]), $past(csr_di[3])}))
    else $error("delay pulses wrong");
  AST_DLY_DROP: assert property (!wr_dly |=> !tap_reset && !tap_step && !phase_step)
    else $error("delay pulse too long");
  cover property (wr_cmd && bypass ##1 !sdram_cs_n);
  cover property (csr_re && csr_a == sdram_ctrl_pkg::OFS_DELAY);
  cover property (wr_dly ##1 phase_step);
endmodule

/* File: testbench/test_sdram_ctrl_register_bank.sv */
// Self-checking bench: CSR master and register bank joined by the link
`timescale 1ns/10ps
module test_sdram_ctrl_register_bank;
  typedef struct packed {logic [13:0] a; logic [31:0] d; logic [31:0] e;} row_t;
  logic        clk = 1'h0, rst_n = 1'h0, sw_write = 1'h0, sw_read = 1'h0, refused;
  logic [13:0] sw_addr = 14'h0;
  logic [31:0] sw_wdata = 32'h0, sw_rdata;
  logic        sw_refused, phase_ready = 1'h1;
  logic [1:0]  clock_lock = 2'h2, sched_ba = 2'h1, sdram_ba, t_write_recovery;
  logic        sched_cs_n = 1'h0, sched_we_n = 1'h1, sched_cas_n = 1'h0, sched_ras_n = 1'h1;
  logic [12:0] sched_a = 13'h0A5A, sdram_a;
  logic        sdram_cke, sdram_cs_n, sdram_we_n, sdram_cas_n, sdram_ras_n, bypass, ctrl_reset, cas_latency3;
  logic [2:0]  t_precharge, t_activate;
  logic [10:0] t_refresh_interval;
  logic [3:0]  t_refresh_recovery;
  logic        tap_reset, tap_step, tap_increment, phase_step, phase_increment;
  int          errors = 0, samples_checked = 0;
  wire  [18:0] pins = {sdram_ba, sdram_a, sdram_ras_n, sdram_cas_n, sdram_we_n, sdram_cs_n};
  wire  [23:0] tim = {t_write_recovery, t_refresh_recovery, t_refresh_interval, cas_latency3, t_activate, t_precharge};
  wire  [4:0]  dly = {tap_reset, tap_step, tap_increment, phase_step, phase_increment};
  row_t rows [7] = '{'{14'h0, 32'hFFFF_FFFF, 32'h0000_0007}, '{14'h4, 32'hFFFF_FFF0, 32'h0007_FFF0},
    '{14'h8, 32'hFFFF_FFFF, 32'h00FF_FFFF}, '{14'h8, 32'h0012_3456, 32'h0012_3456},
    '{14'hC, 32'h0000_0006, 32'h0000_00A0}, '{14'h10, 32'hFFFF_FFFF, 32'h0}, '{14'h1, 32'hFFFF_FFFF, 32'h0}};
  csr_link_if u_csr_link_if ();
  sdram_ctrl_csr_master u_sdram_ctrl_csr_master (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata), .sw_refused(sw_refused), .csr(u_csr_link_if.master));
  sdram_ctrl_register_bank u_sdram_ctrl_register_bank (.clk(clk), .rst_n(rst_n), .csr(u_csr_link_if.bank),
    .sched_cs_n(sched_cs_n), .sched_we_n(sched_we_n), .sched_cas_n(sched_cas_n), .sched_ras_n(sched_ras_n),
    .sched_a(sched_a), .sched_ba(sched_ba), .sdram_cke(sdram_cke), .sdram_cs_n(sdram_cs_n), .sdram_we_n(sdram_we_n),
    .sdram_cas_n(sdram_cas_n), .sdram_ras_n(sdram_ras_n), .sdram_a(sdram_a), .sdram_ba(sdram_ba), .bypass(bypass),
    .ctrl_reset(ctrl_reset), .t_precharge(t_precharge), .t_activate(t_activate), .cas_latency3(cas_latency3),
    .t_refresh_interval(t_refresh_interval), .t_refresh_recovery(t_refresh_recovery),
    .t_write_recovery(t_write_recovery), .tap_reset(tap_reset), .tap_step(tap_step), .tap_increment(tap_increment),
    .phase_step(phase_step), .phase_increment(phase_increment), .phase_ready(phase_ready), .clock_lock(clock_lock));
  sdram_ctrl_register_bank_chk u_chk (.clk(clk), .rst_n(rst_n), .csr_a(u_csr_link_if.csr_a),
    .csr_we(u_csr_link_if.csr_we), .csr_re(u_csr_link_if.csr_re), .csr_di(u_csr_link_if.csr_di),
    .csr_do(u_csr_link_if.csr_do), .sched_cs_n(sched_cs_n), .sched_a(sched_a), .sdram_cke(sdram_cke),
    .sdram_cs_n(sdram_cs_n), .sdram_we_n(sdram_we_n), .sdram_cas_n(sdram_cas_n), .sdram_ras_n(sdram_ras_n),
    .sdram_a(sdram_a), .sdram_ba(sdram_ba), .bypass(bypass), .ctrl_reset(ctrl_reset), .tap_reset(tap_reset),
    .tap_step(tap_step), .phase_step(phase_step), .phase_ready(phase_ready), .clock_lock(clock_lock));
  always #2 clk = ~clk;
  task automatic final_report;
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write through the master; returns with the bank's response settled
  task automatic sw_wr(input logic [13:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_write <= 1'h1;
    @(posedge clk);
    sw_write <= 1'h0;
    #1 refused = sw_refused;
    @(posedge clk);
    #1;
  endtask
  task automatic rd_chk(input logic [13:0] a, input logic [31:0] e);
    @(posedge clk);
    sw_addr <= a;
    sw_read <= 1'h1;
    @(posedge clk);
    sw_read <= 1'h0;
    repeat (2) @(posedge clk);
    #1 chk(sw_rdata, e);
  endtask
  initial begin
    #20000;
    errors++;
    final_report;
  end
  initial begin
    logic [31:0] d;
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 7; i++) begin
      sw_wr(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].e);
      if (rows[i].a == 14'h8) chk(32'(tim), rows[i].e);
    end
    sw_wr(14'hC, 32'h1E);
    chk(32'(dly), 32'hF);
    sw_wr(14'hC, 32'h08);
    chk(32'(refused), 32'h1);
    rd_chk(14'hC, 32'hA0);
    sw_wr(14'hC, 32'h1F);
    chk(32'(dly), 32'h10);
    sw_wr(14'hC, 32'h02);
    chk(32'(dly), 32'h8);
    for (int i = 0; i < 4; i++) begin
      d = 32'h0005_ABC0 | (32'h1 << i);
      sw_wr(14'h4, d);
      chk(32'(pins), 32'(d[18:0] ^ 19'hF));
      @(posedge clk);
      #1 chk(32'(pins), {13'h0, d[18:4], 4'hF});
    end
    sw_wr(14'h0, 32'h4);
    sw_wr(14'h4, 32'h0007_FFFF);
    chk(32'(pins), 32'({sched_ba, sched_a, sched_ras_n, sched_cas_n, sched_we_n, sched_cs_n}));
    @(posedge clk);
    sched_ba <= 2'h2;
    sched_a <= 13'h15A5;
    sched_cs_n <= 1'h1;
    sched_ras_n <= 1'h0;
    @(posedge clk);
    #1 chk(32'(pins), 32'h0005_5A53);
    rd_chk(14'h4, 32'h0007_FFF0);
    sw_wr(14'h8, 32'h0);
    chk(32'(refused), 32'h1);
    sw_wr(14'h0, 32'h0);
    chk(32'(refused), 32'h1);
    chk(32'(sdram_cke), 32'h1);
    rd_chk(14'h0, 32'h4);
    rd_chk(14'h8, 32'h0012_3456);
    @(posedge clk);
    rst_n <= 1'h0;
    phase_ready <= 1'h0;
    clock_lock <= 2'h1;
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    #1 chk(32'({sdram_cke, ctrl_reset, bypass, pins}), 32'h0018_000F);
    repeat (4) @(posedge clk);
    rd_chk(14'h0, 32'h3);
    rd_chk(14'h8, 32'h0061_7212);
    rd_chk(14'hC, 32'h40);
    chk(32'(tim), 32'h0061_7212);
    final_report;
  end
endmodule
